/* File: tb/pd_model.sv */
/*
  Powered-device side of the analog interface: answers each request with one stepDone.
  Assumes requests hold until stepDone is taken; results are valid only with stepDone.
*/
`timescale 1ns/1ps
`default_nettype none
module pd_model (
  // clock and reset
  input wire logic        clk,
  input wire logic        rst,
  // requests
  input wire logic        fetCheckReq,
  input wire logic [1:0]  detReq,
  input wire logic        ccReq,
  input wire logic [1:0]  probeReq,
  input wire logic [1:0]  classRstReq,
  input wire logic [1:0]  classEvtReq,
  // behaviour set by the bench
  input wire logic [1:0]  sigOk,
  input wire logic        dual,
  input wire logic        fetBad,
  input wire logic [3:0]  cls,
  input wire logic [3:0]  dly,
  // answers
  output logic            stepDone,
  output logic            sigValid,
  output logic            ccDual,
  output logic            mosfetFault,
  output logic [3:0]      reqClass
);
  logic       busy;
  logic [3:0] cnt;
  logic       tog;
  assign busy = fetCheckReq | (|detReq) | ccReq | (|probeReq) | (|classRstReq) | (|classEvtReq);
  // results toggle outside answers so stale values are never trusted
  assign sigValid    = stepDone ? |(detReq & sigOk) : tog;
  assign ccDual      = stepDone ? dual : tog;
  assign mosfetFault = stepDone ? fetBad : tog;
  assign reqClass    = stepDone ? cls : {4{tog}};
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      stepDone <= 1'b0;
      cnt      <= 4'h0;
      tog      <= 1'b0;
    end else begin
      tog <= ~tog;
      if (stepDone) begin
        stepDone <= 1'b0;
        cnt      <= 4'h0;
      end else if (busy && cnt >= dly) begin
        stepDone <= 1'b1;
      end else if (busy) begin
        cnt <= cnt + 4'h1;
      end
    end
  end
endmodule
`default_nettype wire

/* File: tb/tb.sv */
/*
  Self-checking bench of the port power sequencer.
  Assumes the design and pd_model are compiled first.
*/
`timescale 1ns/1ps
`default_nettype none
module tb;
  localparam int FD = 200;
  localparam int AR = 20;
  logic clk = 1'b0, rst = 1'b1, portFault = 1'b0, dual = 1'b0, fetBad = 1'b0, uvlo = 1'b0, otClr = 1'b0;
  logic [2:0] pins = 3'h7;
  logic [1:0] sigOk = 2'h3, pwrPrev = 2'h0, disc = 2'h0;
  logic [3:0] cls = 4'h0, dly = 4'h0;
  logic stepDone, sigValid, ccDual, mosfetFault, analogReset, fetCheckReq, ccReq, classLong, led;
  logic [1:0] detReq, probeReq, classRstReq, classEvtReq, powerEn;
  logic [3:0] reqClass, grantClass;
  int fails = 0, cmp_count = 0, seed = 86, cyc = 0, relCyc = 0;
  logic [7:0] expQ[$];
  always #50 clk = ~clk;
  poe_port_power_sequencer #(.FIRST_DETECT_CYCLES(FD), .ANALOG_RESET_CYCLES(AR), .FAULT_BACKOFF_CYCLES(10)) uut (
    .clk(clk), .rst(rst), .powerBudgetPins(pins), .stepDone(stepDone), .sigValid(sigValid), .ccDual(ccDual),
    .mosfetFault(mosfetFault), .reqClass(reqClass), .portFault(portFault), .disconnect(disc), .uvloCleared(uvlo),
    .overTempCleared(otClr), .analogReset(analogReset), .fetCheckReq(fetCheckReq), .detReq(detReq), .ccReq(ccReq),
    .probeReq(probeReq), .classRstReq(classRstReq), .classEvtReq(classEvtReq), .classLong(classLong),
    .powerEn(powerEn), .grantClass(grantClass), .led(led));
  pd_model pd (
    .clk(clk), .rst(rst), .fetCheckReq(fetCheckReq), .detReq(detReq), .ccReq(ccReq), .probeReq(probeReq),
    .classRstReq(classRstReq), .classEvtReq(classEvtReq), .sigOk(sigOk), .dual(dual), .fetBad(fetBad),
    .cls(cls), .dly(dly), .stepDone(stepDone), .sigValid(sigValid), .ccDual(ccDual),
    .mosfetFault(mosfetFault), .reqClass(reqClass));
  // ==========================================================================
  // helpers
  function automatic int grantOf(int code, int req);
    int ceil;
    ceil = (code >= 3) ? code + 1 : code + 2;
    return (req < ceil) ? req : ceil;
  endfunction
  function automatic int nEvt(int code, int req);
    int g;
    g = grantOf(code, req);
    return (g <= 3) ? 1 : (g == 4) ? 3 : (g <= 6) ? 4 : 5;
  endfunction
  task automatic push_class(logic [1:0] ps, int n);
    expQ.push_back({4'h4, 2'h0, ps});
    expQ.push_back({4'h5, 2'h0, ps});
    expQ.push_back({4'h6, 2'h1, ps});
    repeat (n - 1) expQ.push_back({4'h6, 2'h0, ps});
  endtask
  // four-pair flow starting on pair set s; dual powers s first, then the other
  task automatic push_four(logic [1:0] s, int n, bit dl);
    expQ.push_back({4'h2, 2'h0, s});
    expQ.push_back(8'h30);
    expQ.push_back({4'h2, 2'h0, ~s});
    push_class(s, n);
    if (dl) begin
      expQ.push_back({4'h7, 2'h0, s});
      push_class(~s, n);
    end
    expQ.push_back(8'h73);
  endtask
  task automatic pulse(logic [4:0] v);
    @(posedge clk) #1 {otClr, uvlo, portFault, disc} = v;
    @(posedge clk) #1 {otClr, uvlo, portFault, disc} = 5'h00;
  endtask
  task automatic do_reset(logic [2:0] code);
    @(posedge clk) #1;
    rst = 1'b1;
    pins = code;
    repeat (16) @(posedge clk);
    #1 rst = 1'b0;
    expQ.push_back(8'h80);
    expQ.push_back(8'h10);
  endtask
  task automatic wait_empty();
    for (int i = 0; i < 3000 && expQ.size() != 0; i++) @(posedge clk);
    repeat (20) @(posedge clk);
    if (expQ.size() != 0) begin
      fails++;
      $display("[FAIL] pending expected 0 seen %0d", expQ.size());
      expQ.delete();
    end
    #1;
  endtask
  task automatic cmp_tok(logic [7:0] seen);
    cmp_count++;
    if (expQ.size() == 0) begin
      fails++;
      $display("[FAIL] step expected none seen %h", seen);
    end else if (expQ[0] !== seen) begin
      fails++;
      $display("[FAIL] step expected %h seen %h", expQ[0], seen);
    end
    if (expQ.size() != 0) void'(expQ.pop_front());
  endtask
  task automatic cmp_val(string name, logic [7:0] expv, logic [7:0] seen);
    cmp_count++;
    if (seen !== expv) begin
      fails++;
      $display("[FAIL] %s expected %h seen %h", name, expv, seen);
    end
  endtask
  task automatic check_mon(int code);
    cmp_val("grant", 8'(grantOf(code, cls)), {4'h0, grantClass});
    cmp_val("led", 8'h01, {7'h00, led});
  endtask
  task automatic cmp_range(int seen, int lo, int hi);
    cmp_count++;
    if (seen < lo || seen > hi) begin
      fails++;
      $display("[FAIL] delay expected %0d..%0d seen %0d", lo, hi, seen);
    end
  endtask
  task automatic final_report();
    $display("fails %0d cmp_count %0d", fails, cmp_count);
    if (fails == 0 && cmp_count > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask
  // ==========================================================================
  // watcher
  always @(negedge clk) begin
    if (rst) begin
      relCyc = 0;
      pwrPrev = 2'h0;
    end else begin
      if (analogReset === 1'b1) begin
        cmp_tok(8'h80);
        cmp_range(relCyc, AR, AR + 12);
      end
      if (stepDone === 1'b1) begin
        if (fetCheckReq === 1'b1) cmp_range(relCyc, FD, FD + 8);
        if (fetCheckReq === 1'b1) cmp_tok(8'h10);
        else if (|detReq) cmp_tok({4'h2, 2'h0, detReq});
        else if (ccReq === 1'b1) cmp_tok(8'h30);
        else if (|probeReq) cmp_tok({4'h4, 2'h0, probeReq});
        else if (|classRstReq) cmp_tok({4'h5, 2'h0, classRstReq});
        else if (|classEvtReq) cmp_tok({4'h6, 1'b0, classLong, classEvtReq});
      end
      if (powerEn !== pwrPrev) cmp_tok({4'h7, 2'h0, powerEn});
      pwrPrev = powerEn;
    end
  end
  always @(posedge clk) begin
    cyc++;
    relCyc++;
    if (cyc == 20000) begin
      fails++;
      final_report();
    end
  end
  // ==========================================================================
  // scenarios
  initial begin
    cls = 4'(unsigned'($random(seed)) % 9);
    do_reset(3'h7);
    push_four(2'h1, nEvt(7, cls), 1'b0);
    repeat (60) @(posedge clk);
    #1 pins = 3'h0;
    wait_empty();
    check_mon(7);
    expQ.push_back(8'h70);
    push_four(2'h2, nEvt(7, cls), 1'b0);
    pulse(5'h04);
    wait_empty();
    check_mon(7);
    dual = 1'b1;
    dly = 4'h3;
    cls = 4'h8;
    do_reset(3'h3);
    push_four(2'h1, 3, 1'b1);
    wait_empty();
    check_mon(3);
    dly = 4'(unsigned'($random(seed)) % 4);
    cls = 4'(unsigned'($random(seed)) % 9);
    sigOk = 2'h2;
    do_reset(3'h2);
    expQ.push_back(8'h21);
    expQ.push_back(8'h22);
    push_class(2'h2, nEvt(2, cls));
    expQ.push_back(8'h72);
    expQ.push_back(8'h21);
    push_class(2'h1, nEvt(2, cls));
    expQ.push_back(8'h73);
    wait (powerEn === 2'h2);
    #1 sigOk = 2'h3;
    wait_empty();
    check_mon(2);
    expQ.push_back(8'h72);
    expQ.push_back(8'h21);
    push_class(2'h1, nEvt(2, cls));
    expQ.push_back(8'h73);
    pulse(5'h01);
    wait_empty();
    check_mon(2);
    @(posedge clk) #1 pins = 3'h7;
    repeat (8) @(posedge clk);
    expQ.push_back(8'h70);
    push_four(2'h1, nEvt(7, cls), 1'b1);
    pulse(5'h08);
    wait_empty();
    check_mon(7);
    @(posedge clk) #1 pins = 3'h2;
    repeat (8) @(posedge clk);
    expQ.push_back(8'h70);
    expQ.push_back(8'h22);
    push_class(2'h2, nEvt(2, cls));
    expQ.push_back(8'h72);
    expQ.push_back(8'h21);
    push_class(2'h1, nEvt(2, cls));
    expQ.push_back(8'h73);
    pulse(5'h10);
    wait_empty();
    check_mon(2);
    fetBad = 1'b1;
    do_reset(3'h5);
    wait_empty();
    repeat (300) @(posedge clk);
    final_report();
  end
endmodule
`default_nettype wire

/* File: verilog/delay_if.sv */
/*
  Load/done carrier between the sequencer and its delay counters.
  Assumes both ends share one clock.
*/
`timescale 1ns/1ps
`default_nettype none
`include "poe_seq_regs.svh"
interface delay_if;
  logic               load;
  logic [`DLY_W-1:0]  value;
  logic               done;
  modport ctrl (output load, output value, input done);
  modport tmr  (input load, input value, output done);
endinterface
`default_nettype wire

/* File: verilog/delay_timer.sv */
/*
  Down counter: load starts it, done pulses one cycle as it reaches zero.
  Assumes value is at least one; zero never finishes.
*/
`timescale 1ns/1ps
`default_nettype none
`include "poe_seq_regs.svh"
module delay_timer (
  // clock and reset
  input wire logic  clk,
  input wire logic  rst,
  // control
  delay_if.tmr      t
);
  logic [`DLY_W-1:0] cnt_q;
  logic              done_q;

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      cnt_q <= '0;
    end else if (t.load) begin
      cnt_q <= t.value;
    end else if (cnt_q != '0) begin
      cnt_q <= cnt_q - `DLY_W'(1);
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      done_q <= 1'b0;
    end else begin
      done_q <= !t.load && (cnt_q == `DLY_W'(1));
    end
  end

  assign t.done = done_q;
endmodule
`default_nettype wire

/* File: verilog/pin_sync.sv */
/*
  Three-stage pin synchroniser; output follows once stages two and three agree.
  Assumes asynchronous pins.
*/
`timescale 1ns/1ps
`default_nettype none
module pin_sync #(
  parameter int W = 3
) (
  // clock and reset
  input wire logic          clk,
  input wire logic          rst,
  // pins
  input wire logic [W-1:0]  pinIn,
  output logic [W-1:0]      pinOut
);
  logic [W-1:0] s1_q;
  logic [W-1:0] s2_q;
  logic [W-1:0] s3_q;
  logic [W-1:0] out_q;

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      s1_q  <= '0;
      s2_q  <= '0;
      s3_q  <= '0;
      out_q <= '0;
    end else begin
      s1_q <= pinIn;
      s2_q <= s1_q;
      s3_q <= s2_q;
      for (int i = 0; i < W; i++) begin
        if (s2_q[i] == s3_q[i]) begin
          out_q[i] <= s3_q[i];
        end
      end
    end
  end

  assign pinOut = out_q;
endmodule
`default_nettype wire

/* File: verilog/poe_port_power_sequencer.sv */
/*
  Sequencer of one PoE source port: boot, analog reset, MOSFET check, detection,
  connection check, probe, class reset, class events, power, monitoring.
  Assumes the analog side answers every request except analogReset with one stepDone pulse on clk.
*/
`timescale 1ns/1ps
`default_nettype none
`include "poe_seq_regs.svh"
module poe_port_power_sequencer #(
  parameter int FIRST_DETECT_CYCLES  = `FIRST_DETECT_CYCLES,
  parameter int ANALOG_RESET_CYCLES  = `ANALOG_RESET_CYCLES,
  parameter int FAULT_BACKOFF_CYCLES = `FAULT_BACKOFF_CYCLES
) (
  // clock and reset
  input wire logic         clk,
  input wire logic         rst,
  // configuration pins
  input wire logic [2:0]   powerBudgetPins,
  // analog answers
  input wire logic         stepDone,
  input wire logic         sigValid,
  input wire logic         ccDual,
  input wire logic         mosfetFault,
  input wire logic [3:0]   reqClass,
  // analog events
  input wire logic         portFault,
  input wire logic [1:0]   disconnect,
  input wire logic         uvloCleared,
  input wire logic         overTempCleared,
  // analog requests
  output logic             analogReset,
  output logic             fetCheckReq,
  output logic [1:0]       detReq,
  output logic             ccReq,
  output logic [1:0]       probeReq,
  output logic [1:0]       classRstReq,
  output logic [1:0]       classEvtReq,
  output logic             classLong,
  output logic [1:0]       powerEn,
  output logic [3:0]       grantClass,
  // indicator
  output logic             led
);

  // ==========================================================================
  // state and timers
  poe_seq_pkg::seq_state_t state_q;
  logic [2:0]              pins;
  logic [3:0]              ceiling_q;
  logic                    fourPair_q;
  logic                    startSel_q;
  logic                    curPair_q;
  logic                    detPhase_q;
  logic                    dual_q;
  logic [3:0]              req_q;
  logic [3:0]              grant_q;
  logic [2:0]              evtCnt_q;
  logic [1:0]              power_q;
  logic                    firstDone_q;
  logic                    loadA_q;
  logic [`DLY_W-1:0]       valueA_q;
  logic                    loadB_q;
  logic [`LED_DIV_W-1:0]   ledDiv_q;
  logic                    led_q;
  logic                    sampleNow;
  logic                    abort;
  logic                    running;
  logic [1:0]              curMask;
  logic [2:0]              needEvt;

  delay_if tmrA ();
  delay_if tmrB ();

  assign tmrA.load  = loadA_q;
  assign tmrA.value = valueA_q;
  assign tmrB.load  = loadB_q;
  assign tmrB.value = `DLY_W'(FIRST_DETECT_CYCLES);

  delay_timer u_tmr_a (
    .clk (clk),
    .rst (rst),
    .t   (tmrA)
  );

  delay_timer u_tmr_b (
    .clk (clk),
    .rst (rst),
    .t   (tmrB)
  );

  pin_sync #(.W(3)) u_pin_sync (
    .clk    (clk),
    .rst    (rst),
    .pinIn  (powerBudgetPins),
    .pinOut (pins)
  );

  // ==========================================================================
  // budget pins
  function automatic logic [3:0] ceilingOf(input logic [2:0] code);
    case (code)
      3'h7:    ceilingOf = `CEIL_CODE7;
      3'h6:    ceilingOf = `CEIL_CODE6;
      3'h5:    ceilingOf = `CEIL_CODE5;
      3'h4:    ceilingOf = `CEIL_CODE4;
      3'h3:    ceilingOf = `CEIL_CODE3;
      3'h2:    ceilingOf = `CEIL_CODE2;
      3'h1:    ceilingOf = `CEIL_CODE1;
      default: ceilingOf = `CEIL_CODE0;
    endcase
  endfunction

  // events per granted class, long first pulse included
  function automatic logic [2:0] eventsOf(input logic [3:0] cls);
    if (cls >= 4'h7) begin
      eventsOf = 3'h5;
    end else if (cls >= 4'h5) begin
      eventsOf = 3'h4;
    end else if (cls == 4'h4) begin
      eventsOf = 3'h3;
    end else begin
      eventsOf = 3'h1;
    end
  endfunction

  // sampled only at boot or on auto-clear
  assign sampleNow = (state_q == poe_seq_pkg::S_BOOT && tmrA.done)
                     || uvloCleared || overTempCleared;

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      ceiling_q  <= `CEIL_CODE0;
      fourPair_q <= 1'b0;
    end else if (sampleNow) begin
      ceiling_q  <= ceilingOf(pins);
      fourPair_q <= (pins >= `BUDGET_FOUR_PAIR_MIN);
    end
  end

  // ==========================================================================
  // sequence
  assign running = state_q >= poe_seq_pkg::S_IDLE && state_q <= poe_seq_pkg::S_MON;
  assign abort   = running && (portFault || uvloCleared || overTempCleared);
  assign curMask = curPair_q ? 2'h2 : 2'h1;
  assign needEvt = eventsOf(grant_q);

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      state_q    <= poe_seq_pkg::S_BOOT;
      loadA_q    <= 1'b1;
      valueA_q   <= `PIN_SETTLE_CYCLES;
      startSel_q <= 1'b0;
      curPair_q  <= 1'b0;
      detPhase_q <= 1'b0;
      dual_q     <= 1'b0;
      evtCnt_q   <= 3'h0;
    end else begin
      loadA_q <= 1'b0;
      if (abort) begin
        state_q  <= poe_seq_pkg::S_FAULT;
        loadA_q  <= 1'b1;
        valueA_q <= `DLY_W'(FAULT_BACKOFF_CYCLES);
      end else if (running && fourPair_q && |(disconnect & power_q)) begin
        state_q <= poe_seq_pkg::S_IDLE;
      end else begin
        case (state_q)
          poe_seq_pkg::S_BOOT: begin
            if (tmrA.done) begin
              state_q  <= poe_seq_pkg::S_ARST_WAIT;
              loadA_q  <= 1'b1;
              // boot overhead taken off so the pulse lands inside the limit
              valueA_q <= `DLY_W'(ANALOG_RESET_CYCLES) - `PIN_SETTLE_CYCLES - `DLY_W'(4);
            end
          end
          poe_seq_pkg::S_ARST_WAIT: begin
            if (tmrA.done) begin
              state_q <= poe_seq_pkg::S_ARST;
            end
          end
          poe_seq_pkg::S_ARST: begin
            state_q <= poe_seq_pkg::S_FIRST_WAIT;
          end
          poe_seq_pkg::S_FIRST_WAIT: begin
            if (firstDone_q) begin
              state_q <= poe_seq_pkg::S_FET;
            end
          end
          poe_seq_pkg::S_FET: begin
            if (stepDone) begin
              state_q <= mosfetFault ? poe_seq_pkg::S_ERR : poe_seq_pkg::S_IDLE;
            end
          end
          poe_seq_pkg::S_IDLE: begin
            detPhase_q <= 1'b0;
            if (fourPair_q) begin
              curPair_q  <= startSel_q;
              startSel_q <= !startSel_q;
              state_q    <= poe_seq_pkg::S_DET;
            end else if (&power_q) begin
              state_q <= poe_seq_pkg::S_MON;
            end else begin
              curPair_q <= power_q[curPair_q] ? !curPair_q : curPair_q;
              state_q   <= poe_seq_pkg::S_DET;
            end
          end
          poe_seq_pkg::S_DET: begin
            if (stepDone) begin
              if (!sigValid) begin
                state_q <= poe_seq_pkg::S_IDLE;
                if (!fourPair_q) begin
                  curPair_q <= !curPair_q;
                end
              end else if (!fourPair_q) begin
                state_q <= poe_seq_pkg::S_PROBE;
              end else if (!detPhase_q) begin
                state_q <= poe_seq_pkg::S_CC;
              end else begin
                curPair_q <= !curPair_q;
                state_q   <= poe_seq_pkg::S_PROBE;
              end
            end
          end
          poe_seq_pkg::S_CC: begin
            if (stepDone) begin
              dual_q     <= ccDual;
              detPhase_q <= 1'b1;
              curPair_q  <= !curPair_q;
              state_q    <= poe_seq_pkg::S_DET;
            end
          end
          poe_seq_pkg::S_PROBE: begin
            if (stepDone) begin
              state_q <= poe_seq_pkg::S_CRST;
            end
          end
          poe_seq_pkg::S_CRST: begin
            if (stepDone) begin
              evtCnt_q <= 3'h0;
              state_q  <= poe_seq_pkg::S_CLASS;
            end
          end
          poe_seq_pkg::S_CLASS: begin
            if (stepDone) begin
              evtCnt_q <= evtCnt_q + 3'h1;
              if (evtCnt_q + 3'h1 >= needEvt) begin
                state_q <= poe_seq_pkg::S_POWER;
              end
            end
          end
          poe_seq_pkg::S_POWER: begin
            if (fourPair_q && dual_q && !power_q[!curPair_q]) begin
              curPair_q <= !curPair_q;
              state_q   <= poe_seq_pkg::S_PROBE;
            end else if (fourPair_q) begin
              state_q <= poe_seq_pkg::S_MON;
            end else begin
              curPair_q <= !curPair_q;
              state_q   <= poe_seq_pkg::S_IDLE;
            end
          end
          poe_seq_pkg::S_MON: begin
            if (!fourPair_q && |(disconnect & power_q)) begin
              state_q <= poe_seq_pkg::S_IDLE;
            end
          end
          poe_seq_pkg::S_FAULT: begin
            if (tmrA.done) begin
              state_q <= poe_seq_pkg::S_IDLE;
            end
          end
          poe_seq_pkg::S_ERR: begin
            state_q <= poe_seq_pkg::S_ERR;
          end
          default: begin
            state_q <= poe_seq_pkg::S_IDLE;
          end
        endcase
      end
    end
  end

  // first detection delay runs from reset release
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      loadB_q     <= 1'b1;
      firstDone_q <= 1'b0;
    end else begin
      loadB_q <= 1'b0;
      if (tmrB.done) begin
        firstDone_q <= 1'b1;
      end
    end
  end

  // ==========================================================================
  // class result and grant
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      req_q   <= 4'h0;
      grant_q <= 4'h0;
    end else if (state_q == poe_seq_pkg::S_PROBE && stepDone) begin
      req_q   <= reqClass;
      grant_q <= (reqClass > ceiling_q) ? ceiling_q : reqClass;
    end
  end

  // ==========================================================================
  // port power
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      power_q <= 2'h0;
    end else if (abort || (running && fourPair_q && |(disconnect & power_q))) begin
      power_q <= 2'h0;
    end else if (state_q == poe_seq_pkg::S_POWER) begin
      power_q <= (fourPair_q && !dual_q) ? 2'h3 : (power_q | curMask);
    end else if (!fourPair_q) begin
      power_q <= power_q & ~disconnect;
    end
  end

  // ==========================================================================
  // requests to the analog side
  always_comb begin
    analogReset = (state_q == poe_seq_pkg::S_ARST);
    fetCheckReq = (state_q == poe_seq_pkg::S_FET);
    ccReq       = (state_q == poe_seq_pkg::S_CC);
    detReq      = (state_q == poe_seq_pkg::S_DET)   ? curMask : 2'h0;
    probeReq    = (state_q == poe_seq_pkg::S_PROBE) ? curMask : 2'h0;
    classRstReq = (state_q == poe_seq_pkg::S_CRST)  ? curMask : 2'h0;
    classEvtReq = (state_q == poe_seq_pkg::S_CLASS) ? curMask : 2'h0;
    classLong   = (state_q == poe_seq_pkg::S_CLASS) && (evtCnt_q == 3'h0);
  end

  assign powerEn    = power_q;
  assign grantClass = grant_q;

  // ==========================================================================
  // indicator
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      ledDiv_q <= '0;
      led_q    <= 1'b0;
    end else begin
      ledDiv_q <= ledDiv_q + `LED_DIV_W'(1);
      if (state_q == poe_seq_pkg::S_ERR || state_q == poe_seq_pkg::S_FAULT) begin
        led_q <= ledDiv_q[`LED_FAST_BIT];
      end else if (state_q == poe_seq_pkg::S_MON && power_q != 2'h0) begin
        led_q <= 1'b1;
      end else begin
        led_q <= ledDiv_q[`LED_DIV_W-1];
      end
    end
  end

  assign led = led_q;

  // ==========================================================================
  // checks
  sequence sProbeDone;
    (probeReq != 2'h0) && stepDone;
  endsequence

  sequence sResetDone;
    (classRstReq != 2'h0) && stepDone;
  endsequence

  a_probe_reset_order: assert property (@(posedge clk) disable iff (rst)
    sProbeDone |=> (classRstReq == $past(probeReq)))
    else $error("class reset did not follow probe");

  a_long_first_pulse: assert property (@(posedge clk) disable iff (rst)
    sResetDone |=> classLong && (classEvtReq != 2'h0))
    else $error("classification did not open with long pulse");

  a_mosfet_error_stop: assert property (@(posedge clk) disable iff (rst)
    (fetCheckReq && stepDone && mosfetFault) |=> (detReq == 2'h0) [*8])
    else $error("detection after mosfet fault");

  a_no_early_detect: assert property (@(posedge clk) disable iff (rst)
    (detReq != 2'h0) |-> firstDone_q)
    else $error("detection before first detect delay");

  a_fault_drops_power: assert property (@(posedge clk) disable iff (rst)
    (running && portFault) |=> (powerEn == 2'h0) ##1 (state_q == poe_seq_pkg::S_FAULT))
    else $error("power kept after fault");

  a_grant_demoted: assert property (@(posedge clk) disable iff (rst)
    $rose(state_q == poe_seq_pkg::S_CLASS) |-> (grantClass <= ceiling_q) && (grantClass <= req_q))
    else $error("grant above ceiling or request");

  a_pins_ignored: assert property (@(posedge clk) disable iff (rst)
    !sampleNow |=> $stable(ceiling_q) && $stable(fourPair_q))
    else $error("budget changed outside sampling");

  a_start_swapped: assert property (@(posedge clk) disable iff (rst)
    (state_q == poe_seq_pkg::S_IDLE && fourPair_q && !abort) |=> (startSel_q != $past(startSel_q)))
    else $error("start pair set not swapped");

  a_cc_four_pair: assert property (@(posedge clk) disable iff (rst)
    ccReq |-> fourPair_q && (detReq == 2'h0))
    else $error("connection check in two-pair mode");

  a_analog_reset_pulse: assert property (@(posedge clk) disable iff (rst)
    analogReset |=> !analogReset && (state_q == poe_seq_pkg::S_FIRST_WAIT))
    else $error("analog reset not a single pulse");

endmodule
`default_nettype wire

/* File: verilog/poe_seq_pkg.sv */
/*
  Types of the port power sequencer.
  Assumes nothing beyond a SystemVerilog compiler.
*/
package poe_seq_pkg;
  typedef enum logic [3:0] {
    S_BOOT = 4'h0, S_ARST_WAIT = 4'h1, S_ARST = 4'h2, S_FIRST_WAIT = 4'h3,
    S_FET = 4'h4, S_IDLE = 4'h5, S_DET = 4'h6, S_CC = 4'h7,
    S_PROBE = 4'h8, S_CRST = 4'h9, S_CLASS = 4'hA, S_POWER = 4'hB,
    S_MON = 4'hC, S_FAULT = 4'hD, S_ERR = 4'hE
  } seq_state_t;
endpackage

/* File: verilog/poe_seq_regs.svh */
/*
  Constants of the port power sequencer: pin codes, class ceilings, timing counts.
  Assumes a 10 MHz controller clock; included by bare name, definitions only.
*/
`ifndef POE_SEQ_REGS_SVH
`define POE_SEQ_REGS_SVH

// ==========================================================================
// timing
`define SEQ_CLK_HZ              10000000
`define ANALOG_RESET_DELAY_US   300
`define ANALOG_RESET_CYCLES     ((`ANALOG_RESET_DELAY_US * (`SEQ_CLK_HZ / 1000000)))
`define FIRST_DETECT_DELAY_MS   45
`define FIRST_DETECT_CYCLES     ((`FIRST_DETECT_DELAY_MS * (`SEQ_CLK_HZ / 1000)))
`define PIN_SETTLE_CYCLES       20'h00008
`define FAULT_BACKOFF_CYCLES    1000
`define DLY_W                   20
`define LED_DIV_W               22
`define LED_FAST_BIT            19

// ==========================================================================
// budget pin codes
`define BUDGET_FOUR_PAIR_MIN    3'h3
`define CEIL_CODE7              4'h8
`define CEIL_CODE6              4'h7
`define CEIL_CODE5              4'h6
`define CEIL_CODE4              4'h5
`define CEIL_CODE3              4'h4
`define CEIL_CODE2              4'h4
`define CEIL_CODE1              4'h3
`define CEIL_CODE0              4'h2

`endif
